// ===== hw/fqlr_core.sv
// Instruction interpreter: read parameters, four-line mode, lock bits, software reset
//
// Overview of operation
// - Read-parameter instruction ignored in serial mode
// - Reset gives 8-byte wrap, 2 dummy clocks
// - Parameter bits 5:4 select 2/4/6/8 dummies
// - Parameter bits 1:0 select 8/16/32/64 wrap
// - Programmed dummies only for 0B/EB/0C, four-line
// - Serial wrap setting kept into four-line mode
// - Wrap read wraps inside its window
// - DTR wrap read uses parameter wrap length
// - Enter four-line mode only with quad enable
// - Exit instruction returns to serial; modes exclusive
// - Mode switch keeps latch and wrap
// - Lock bits protect only when select set
// - Lock bits volatile, all set at reset
// - Individual lock needs write enable latch
// - Individual unlock needs write enable latch
// - Lock read-back byte, LSB shows lock
// - Global lock/unlock, latch required, no address
// - Reset-enable then reset; others cancel arming
// - Reset restores power-on volatile state
// - Reset busy interval refuses all instructions
`timescale 1ns/10ps
`default_nettype none
module fqlr_core
  import fqlr_pkg::*;
#(
  parameter int RST_CYCLES = fqlr_pkg::RST_CYCLES_DFLT
) (
  input wire logic clock,                       // System clock, 250 MHz
  input wire logic rst,                         // Synchronous reset, active high
  input wire logic cs_n,                        // Chip select pin, active low
  input wire logic sck,                         // Serial clock pin
  input wire logic [3:0] io_in,                 // Data pins, input side
  output logic [3:0] io_out,                    // Data pins, output side
  output logic [3:0] io_oe_n,                   // Data pin enables, low drives
  input wire logic quad_enable,                 // Quad enable status bit
  input wire logic write_enable_latch,          // Write enable latch status
  input wire logic per_region_protect_select,   // Selects lock bits for protection
  input wire logic range_protect,               // Protection from range bits
  input wire logic [23:0] prot_addr,            // Address queried for protection
  output logic prot_locked,                     // Protection of prot_addr
  output logic [23:0] rd_addr,                  // Array read address
  output logic rd_strobe,                       // Pulse: rd_addr changed
  input wire logic [7:0] rd_data,               // Array byte at rd_addr
  output logic four_line_command_mode,          // Four-line mode active
  output fqlr_pkg::fqlr_rd_param_s rd_param,    // Current read parameters
  output logic busy,                            // Reset interval in progress
  output logic soft_reset                       // Pulse: software reset accepted
);

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  logic [5:0] pin_lvl; // Filtered {cs_n, sck, io}
  logic [5:0] pin_rise; // Rise pulses
  logic [5:0] pin_fall; // Fall pulses
  logic cs_rise;
  logic cs_fall;
  logic sck_rise;
  logic sck_fall;
  logic [3:0] io_lvl;

  fqlr_pin_sync #(
    .WIDTH(6),
    .INIT(6'h20)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .din({cs_n, sck, io_in}),
    .lvl(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign cs_rise = pin_rise[5];
  assign cs_fall = pin_fall[5];
  assign sck_rise = pin_rise[4] & ~pin_lvl[5];
  assign sck_fall = pin_fall[4] & ~pin_lvl[5];
  assign io_lvl = pin_lvl[3:0];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fqlr_phase_e phase_r, phase_nxt;        // Frame phase
  logic qpi_r, qpi_nxt;                   // Four-line mode flag
  fqlr_rd_param_s rp_r, rp_nxt;           // Read parameters
  logic [LOCK_COUNT-1:0] lock_r, lock_nxt; // Volatile lock bits
  logic armed_r, armed_nxt;               // Reset enable armed
  logic [15:0] busy_cnt_r, busy_cnt_nxt;  // Reset interval counter
  logic [7:0] cmd_r, cmd_nxt;             // Current instruction
  logic [31:0] sh_r, sh_nxt;              // Input shifter
  logic [5:0] cnt_r, cnt_nxt;             // Bits or clocks in phase
  logic [23:0] addr_r, addr_nxt;          // Captured / running address
  logic [7:0] out_sr_r, out_sr_nxt;       // Output shifter
  logic [3:0] out_cnt_r, out_cnt_nxt;     // Output bits left in byte
  logic [3:0] io_out_r, io_out_nxt;       // Pin data
  logic [3:0] io_oe_n_r, io_oe_n_nxt;     // Pin enables
  logic rd_strobe_r, rd_strobe_nxt;       // Address change pulse
  logic soft_reset_r, soft_reset_nxt;     // Reset pulse
  logic prot_r, prot_nxt;                 // Protection answer

  // Decode temporaries
  logic [5:0] step;       // Bits per clock
  logic [5:0] cnt_inc;    // Counter after this clock
  logic [31:0] sh_in;     // Shifter after this clock
  logic is_read;          // Array read instruction
  logic is_wrap;          // Wrapping read
  logic out_edge;         // Output shift edge
  logic [7:0] byte_cur;   // Byte being driven
  logic [23:0] wmask;     // Wrap window mask

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    phase_nxt = phase_r;
    qpi_nxt = qpi_r;
    rp_nxt = rp_r;
    lock_nxt = lock_r;
    armed_nxt = armed_r;
    busy_cnt_nxt = busy_cnt_r;
    cmd_nxt = cmd_r;
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    addr_nxt = addr_r;
    out_sr_nxt = out_sr_r;
    out_cnt_nxt = out_cnt_r;
    io_out_nxt = io_out_r;
    io_oe_n_nxt = io_oe_n_r;
    rd_strobe_nxt = 1'b0;
    soft_reset_nxt = 1'b0;
    prot_nxt = per_region_protect_select ? lock_r[fqlr_lock_index(prot_addr)] : range_protect;
    step = qpi_r ? 6'h04 : 6'h01;
    cnt_inc = cnt_r + step;
    sh_in = qpi_r ? {sh_r[27:0], io_lvl} : {sh_r[30:0], io_lvl[0]};
    is_read = (cmd_r == OP_FAST_RD) || (cmd_r == OP_QIO_RD) || (cmd_r == OP_WRAP_RD) || (cmd_r == OP_DTR_WRAP_RD);
    is_wrap = (cmd_r == OP_WRAP_RD) || (cmd_r == OP_DTR_WRAP_RD);
    out_edge = sck_fall || (sck_rise && (cmd_r == OP_DTR_WRAP_RD));
    byte_cur = out_sr_r;
    wmask = (WRAP_BASE_BYTES << rp_r.wrap_code) - 24'h000001;

    // Reset interval countdown
    if (busy_cnt_r != 16'h0000)
      busy_cnt_nxt = busy_cnt_r - 16'h0001;

    if (cs_rise)
    begin
      // Frame end: release pins, execute completed instruction
      phase_nxt = PH_IDLE;
      io_oe_n_nxt = 4'hF;
      if (phase_r == PH_DONE)
      begin
        case (cmd_r)
          OP_SET_RD_PARAM:
          begin
            rp_nxt.dummy_code = sh_r[DUMMY_FIELD_LSB +: 2];
            rp_nxt.wrap_code = sh_r[WRAP_FIELD_LSB +: 2];
          end
          OP_SET_WRAP: rp_nxt.wrap_code = sh_r[SERIAL_WRAP_LSB +: 2];
          OP_ENTER_QUAD: qpi_nxt = quad_enable;
          OP_EXIT_QUAD: qpi_nxt = 1'b0;
          OP_LOCK: if (write_enable_latch) lock_nxt[fqlr_lock_index(addr_r)] = 1'b1;
          OP_UNLOCK: if (write_enable_latch) lock_nxt[fqlr_lock_index(addr_r)] = 1'b0;
          OP_GLB_LOCK: if (write_enable_latch) lock_nxt = '1;
          OP_GLB_UNLOCK: if (write_enable_latch) lock_nxt = '0;
          OP_RST_EN: armed_nxt = 1'b1;
          OP_RST:
          begin
            if (armed_r)
            begin
              qpi_nxt = 1'b0;
              rp_nxt.dummy_code = RST_DUMMY_CODE;
              rp_nxt.wrap_code = RST_WRAP_CODE;
              lock_nxt = '1;
              soft_reset_nxt = 1'b1;
              busy_cnt_nxt = 16'(RST_CYCLES);
            end
            armed_nxt = 1'b0;
          end
          default: ;
        endcase
      end
    end
    else if (cs_fall)
    begin
      phase_nxt = (busy_cnt_r != 16'h0000) ? PH_IGNORE : PH_CMD;
      cnt_nxt = 6'h00;
      out_cnt_nxt = 4'h0;
    end
    else if (sck_rise)
    begin
      case (phase_r)
        PH_CMD:
        begin
          sh_nxt = sh_in;
          cnt_nxt = cnt_inc;
          if (cnt_inc == CMD_BITS)
          begin
            cmd_nxt = sh_in[7:0];
            cnt_nxt = 6'h00;
            if ((sh_in[7:0] != OP_RST_EN) && (sh_in[7:0] != OP_RST))
              armed_nxt = 1'b0;
            case (sh_in[7:0])
              // configurable reads only in four-line mode
              OP_FAST_RD, OP_QIO_RD, OP_WRAP_RD, OP_DTR_WRAP_RD: phase_nxt = qpi_r ? PH_ADDR : PH_IGNORE;
              OP_LOCK, OP_UNLOCK, OP_RD_LOCK: phase_nxt = PH_ADDR;
              OP_SET_RD_PARAM: phase_nxt = qpi_r ? PH_ARG : PH_IGNORE;
              OP_SET_WRAP: phase_nxt = qpi_r ? PH_IGNORE : PH_ARG;
              OP_ENTER_QUAD: phase_nxt = qpi_r ? PH_IGNORE : PH_DONE;
              OP_EXIT_QUAD: phase_nxt = qpi_r ? PH_DONE : PH_IGNORE;
              OP_GLB_LOCK, OP_GLB_UNLOCK, OP_RST_EN, OP_RST: phase_nxt = PH_DONE;
              default: phase_nxt = PH_IGNORE;
            endcase
          end
        end
        PH_ADDR:
        begin
          sh_nxt = sh_in;
          cnt_nxt = cnt_inc;
          if (cnt_inc == ADDR_BITS)
          begin
            addr_nxt = sh_in[23:0];
            cnt_nxt = 6'h00;
            rd_strobe_nxt = is_read;
            if (cmd_r == OP_RD_LOCK)
              phase_nxt = PH_OUT;
            else if (is_read)
              phase_nxt = PH_DUMMY;
            else
              phase_nxt = PH_DONE;
          end
        end
        PH_ARG:
        begin
          sh_nxt = sh_in;
          cnt_nxt = cnt_inc;
          if (cnt_inc == ((cmd_r == OP_SET_WRAP) ? SW_ARG_BITS : RP_ARG_BITS))
            phase_nxt = PH_DONE;
        end
        PH_DUMMY:
        begin
          cnt_nxt = cnt_r + 6'h01;
          if ((cnt_r + 6'h01) == ((cmd_r == OP_DTR_WRAP_RD) ? DTR_DUMMY_CLKS : fqlr_dummy_clks(rp_r.dummy_code)))
            phase_nxt = PH_OUT;
        end
        default: ;
      endcase
    end

    // Output shifting, MSB first
    if (!cs_rise && (phase_r == PH_OUT) && out_edge)
    begin
      if (out_cnt_r == 4'h0)
      begin
        if (cmd_r == OP_RD_LOCK)
        begin
          byte_cur = {7'h00, lock_r[fqlr_lock_index(addr_r)]};
        end
        else
        begin
          byte_cur = rd_data;
          rd_strobe_nxt = 1'b1;
          if (is_wrap)
            addr_nxt = (addr_r & ~wmask) | ((addr_r + 24'h000001) & wmask);
          else
            addr_nxt = addr_r + 24'h000001;
        end
        out_cnt_nxt = 4'h8 - step[3:0];
      end
      else
        out_cnt_nxt = out_cnt_r - step[3:0];
      out_sr_nxt = qpi_r ? {byte_cur[3:0], 4'h0} : {byte_cur[6:0], 1'b0};
      // Serial mode drives the second data pin only
      io_out_nxt = qpi_r ? byte_cur[7:4] : {2'h0, byte_cur[7], 1'b0};
      io_oe_n_nxt = qpi_r ? 4'h0 : 4'hD;
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      phase_r <= PH_IDLE;
      qpi_r <= 1'b0;
      rp_r <= '{dummy_code: RST_DUMMY_CODE, wrap_code: RST_WRAP_CODE};
      lock_r <= '1;
      armed_r <= 1'b0;
      busy_cnt_r <= 16'h0000;
      cmd_r <= 8'h00;
      sh_r <= 32'h00000000;
      cnt_r <= 6'h00;
      addr_r <= 24'h000000;
      out_sr_r <= 8'h00;
      out_cnt_r <= 4'h0;
      io_out_r <= 4'h0;
      io_oe_n_r <= 4'hF;
      rd_strobe_r <= 1'b0;
      soft_reset_r <= 1'b0;
      prot_r <= 1'b1;
    end
    else
    begin
      phase_r <= phase_nxt;
      qpi_r <= qpi_nxt;
      rp_r <= rp_nxt;
      lock_r <= lock_nxt;
      armed_r <= armed_nxt;
      busy_cnt_r <= busy_cnt_nxt;
      cmd_r <= cmd_nxt;
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
      addr_r <= addr_nxt;
      out_sr_r <= out_sr_nxt;
      out_cnt_r <= out_cnt_nxt;
      io_out_r <= io_out_nxt;
      io_oe_n_r <= io_oe_n_nxt;
      rd_strobe_r <= rd_strobe_nxt;
      soft_reset_r <= soft_reset_nxt;
      prot_r <= prot_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign io_out = io_out_r;
  assign io_oe_n = io_oe_n_r;
  assign prot_locked = prot_r;
  assign rd_addr = addr_r;
  assign rd_strobe = rd_strobe_r;
  assign four_line_command_mode = qpi_r;
  assign rd_param = rp_r;
  assign busy = (busy_cnt_r != 16'h0000);
  assign soft_reset = soft_reset_r;

endmodule
`default_nettype wire

// ===== hw/fqlr_pin_sync.sv
// Three-stage pin sampler with agreement filter and edge pulses
`timescale 1ns/10ps
`default_nettype none
module fqlr_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clock,             // System clock
  input wire logic rst,               // Synchronous reset
  input wire logic [WIDTH-1:0] din,   // Raw pin levels
  output logic [WIDTH-1:0] lvl,       // Filtered level
  output logic [WIDTH-1:0] rise,      // Rise pulse, ahead of lvl by one cycle
  output logic [WIDTH-1:0] fall       // Fall pulse, ahead of lvl by one cycle
);

  // ----------------------------------------------------------------
  // Sampler state
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] s1_r; // First stage, read only by s2
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] lvl_r;
  logic [WIDTH-1:0] lvl_nxt;

  // Level moves only where stages two and three agree
  always_comb
  begin
    lvl_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & lvl_r);
    rise = lvl_nxt & ~lvl_r;
    fall = ~lvl_nxt & lvl_r;
    lvl = lvl_r;
  end

  // Register stages
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      lvl_r <= INIT;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

endmodule
`default_nettype wire

// ===== hw/fqlr_pkg.sv
// Constants, types and decode helpers for the four-line mode, lock and reset interpreter
package fqlr_pkg;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SET_RD_PARAM = 8'hC0;
  localparam logic [7:0] OP_FAST_RD = 8'h0B;
  localparam logic [7:0] OP_QIO_RD = 8'hEB;
  localparam logic [7:0] OP_WRAP_RD = 8'h0C;
  localparam logic [7:0] OP_DTR_WRAP_RD = 8'h0E;
  localparam logic [7:0] OP_SET_WRAP = 8'h77;
  localparam logic [7:0] OP_ENTER_QUAD = 8'h38;
  localparam logic [7:0] OP_EXIT_QUAD = 8'hFF;
  localparam logic [7:0] OP_LOCK = 8'h36;
  localparam logic [7:0] OP_UNLOCK = 8'h39;
  localparam logic [7:0] OP_RD_LOCK = 8'h3D;
  localparam logic [7:0] OP_GLB_LOCK = 8'h7E;
  localparam logic [7:0] OP_GLB_UNLOCK = 8'h98;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;

  // ----------------------------------------------------------------
  // Field positions, lengths and reset values
  // ----------------------------------------------------------------
  localparam int DUMMY_FIELD_LSB = 4;     // Dummy count field in read parameters
  localparam int WRAP_FIELD_LSB = 0;      // Wrap length field in read parameters
  localparam int SERIAL_WRAP_LSB = 4;     // Wrap field in serial wrap setting byte
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h18;
  localparam logic [5:0] RP_ARG_BITS = 6'h08;
  localparam logic [5:0] SW_ARG_BITS = 6'h20;
  localparam logic [1:0] RST_DUMMY_CODE = 2'h0;  // 2 dummy clocks
  localparam logic [1:0] RST_WRAP_CODE = 2'h0;   // 8-byte wrap
  localparam logic [5:0] DTR_DUMMY_CLKS = 6'h08; // Fixed latency of the DTR wrap read
  localparam logic [23:0] WRAP_BASE_BYTES = 24'h000008;
  localparam int LOCK_COUNT = 62;
  localparam logic [4:0] LAST_BLOCK = 5'h1F;
  localparam logic [5:0] TOP_SECTOR_BASE = 6'h2E;
  localparam logic [5:0] MID_BLOCK_BASE = 6'h0F;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_RST_NS = 30000;
  localparam int RST_CYCLES_DFLT = (T_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {PH_IDLE, PH_CMD, PH_ADDR, PH_ARG, PH_DUMMY, PH_OUT, PH_DONE, PH_IGNORE} fqlr_phase_e;

  typedef struct packed {
    logic [1:0] dummy_code; // dummy_count_field
    logic [1:0] wrap_code;  // wrap_length_field
  } fqlr_rd_param_s;

  // Dummy clocks: 2, 4, 6 or 8
  function automatic logic [5:0] fqlr_dummy_clks(input logic [1:0] code);
    fqlr_dummy_clks = {3'h0, code, 1'b0} + 6'h02;
  endfunction

  // Lock bit index: sectors of first and last block, whole blocks between
  function automatic logic [5:0] fqlr_lock_index(input logic [23:0] a);
    if (a[20:16] == 5'h00)
      fqlr_lock_index = {2'h0, a[15:12]};
    else if (a[20:16] == LAST_BLOCK)
      fqlr_lock_index = TOP_SECTOR_BASE + {2'h0, a[15:12]};
    else
      fqlr_lock_index = MID_BLOCK_BASE + {1'b0, a[20:16]};
  endfunction

endpackage

// ===== tb/fqlr_asserts.sv
// Port checker for the four-line mode, lock and reset interpreter
`timescale 1ns/10ps
`default_nettype none
module fqlr_asserts
  import fqlr_pkg::*;
#(
  parameter int RST_CYCLES = 20
) (
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic cs_n, // Chip select pin
  input wire logic quad_enable, // Quad enable bit
  input wire logic per_region_protect_select, // Lock bit select
  input wire logic range_protect, // Range protection
  input wire logic prot_locked, // Protection answer
  input wire logic [3:0] io_oe_n, // Pin enables, low drives
  input wire logic four_line_command_mode, // Mode flag
  input wire fqlr_pkg::fqlr_rd_param_s rd_param, // Read parameters
  input wire logic busy, // Reset interval
  input wire logic soft_reset // Accepted reset pulse
);
  // ----------------------------------------------------------------
  // Busy length counter
  // ----------------------------------------------------------------
  logic [15:0] busy_cnt_r; // Consecutive busy cycles
  logic [15:0] busy_cnt_nxt; // Next count
  // Count while busy, clear otherwise
  always_comb
  begin
    busy_cnt_nxt = busy ? busy_cnt_r + 16'h0001 : 16'h0000;
  end
  // Register the count
  always_ff @(posedge clock)
  begin
    busy_cnt_r <= rst ? 16'h0000 : busy_cnt_nxt;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // power-on state
  rst_dflt_a: assert property ($fell(rst) |->
    rd_param == 4'h0 && !four_line_command_mode && !busy && prot_locked)
    else $error("reset state wrong");
  soft_pulse_a: assert property (soft_reset |=> !soft_reset)
    else $error("soft reset pulse too long");
  soft_clear_a: assert property (soft_reset |-> ##[0:2] (rd_param == 4'h0 && !four_line_command_mode))
    else $error("soft reset left state");
  busy_start_a: assert property (soft_reset |-> ##[0:2] busy)
    else $error("busy missing after reset");
  busy_len_a: assert property ($fell(busy) |-> busy_cnt_r >= RST_CYCLES - 1 && busy_cnt_r <= RST_CYCLES + 1)
    else $error("busy length wrong");
  busy_hold_a: assert property (busy [*3] |-> $stable(rd_param) && $stable(four_line_command_mode))
    else $error("state changed while busy");
  prot_range_a: assert property (!per_region_protect_select |=> prot_locked == $past(range_protect))
    else $error("protection source wrong");
  serial_oe_a: assert property (!four_line_command_mode && io_oe_n != 4'hF |-> io_oe_n == 4'hD)
    else $error("serial enables wrong");
  quad_oe_a: assert property (four_line_command_mode && io_oe_n != 4'hF |-> io_oe_n == 4'h0)
    else $error("four-line enables wrong");
  cs_release_a: assert property (cs_n [*8] |-> io_oe_n == 4'hF)
    else $error("pins driven while deselected");
  // entry needs quad enable, after frame end
  enter_qe_a: assert property ($rose(four_line_command_mode) |-> $past(quad_enable) && $past(cs_n, 4))
    else $error("bad mode entry");
  // dummy count fixed in serial mode
  dummy_ser_a: assert property ($changed(rd_param.dummy_code) |->
    $past(four_line_command_mode) || soft_reset || $past(soft_reset) || busy)
    else $error("dummy count changed in serial");
endmodule
bind fqlr_core fqlr_asserts #(.RST_CYCLES(RST_CYCLES)) i_chk (.clock, .rst, .cs_n, .quad_enable,
  .per_region_protect_select, .range_protect, .prot_locked, .io_oe_n, .four_line_command_mode, .rd_param,
  .busy, .soft_reset);
`default_nettype wire

// ===== tb/fqlr_core_tb.sv
// Self-checking bench for the interpreter
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module fqlr_core_tb;
  import fqlr_pkg::*;
  logic clock, rst, cs_n, sck, quad_enable, write_enable_latch, per_region_protect_select, range_protect;
  logic prot_locked, rd_strobe, four_line_command_mode, busy, soft_reset;
  logic [3:0] io_in, io_out, io_oe_n;
  logic [23:0] prot_addr, rd_addr;
  logic [7:0] rd_data;
  fqlr_rd_param_s rd_param;
  logic [39:0] rx; // Read-back shift
  int fail_count = 0;
  int n_checks = 0;
  int k;
  // Parameter byte beside expected fields
  logic [11:0] rows [5] = '{12'h000, 12'h115, 12'h22A, 12'h33F, 12'hCE2};
  // Array content follows address
  assign rd_data = rd_addr[7:0] ^ 8'hA5;
  fqlr_core #(.RST_CYCLES(400)) i_dut (.clock, .rst, .cs_n, .sck, .io_in, .io_out, .io_oe_n, .quad_enable,
    .write_enable_latch, .per_region_protect_select, .range_protect, .prot_addr, .prot_locked, .rd_addr,
    .rd_strobe, .rd_data, .four_line_command_mode, .rd_param, .busy, .soft_reset);
  fqlr_host i_host (.clock, .io_out, .io_oe_n, .cs_n, .sck, .io_in);
  // 250 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmd(input bit q, input logic [63:0] tx, input int nu);
    i_host.xfer(q, tx, nu, 0, rx);
  endtask
  task automatic prot(input logic [23:0] a, input logic e);
    prot_addr = a;
    repeat (2) @(negedge clock);
    `CHK("prot_locked", e, prot_locked)
  endtask
  // Main sequence
  initial
  begin
    rst = 1'b1;
    quad_enable = 1'b0;
    write_enable_latch = 1'b0;
    per_region_protect_select = 1'b1;
    range_protect = 1'b0;
    prot_addr = 24'h0;
    repeat (4) @(negedge clock);
    rst = 1'b0;
    repeat (8) @(negedge clock);
    `CHK("rd_param", 4'h0, rd_param)
    prot(24'h000000, 1'b1);
    per_region_protect_select = 1'b0;
    prot(24'h000000, 1'b0);
    per_region_protect_select = 1'b1;
    cmd(0, {8'hC0, 8'h33}, 16);
    `CHK("rd_param", 4'h0, rd_param)
    cmd(0, {8'h77, 24'h0, 8'h20}, 40);
    `CHK("wrap", 2'h2, rd_param.wrap_code)
    cmd(0, 8'h38, 8);
    `CHK("mode", 1'b0, four_line_command_mode)
    quad_enable = 1'b1;
    cmd(0, 8'h38, 8);
    `CHK("mode", 1'b1, four_line_command_mode)
    `CHK("wrap", 2'h2, rd_param.wrap_code)
    foreach (rows[i])
    begin
      cmd(1, {8'hC0, rows[i][11:4]}, 4);
      `CHK("rd_param", rows[i][3:0], rd_param)
    end
    cmd(1, {8'hC0, 8'h10}, 4);
    i_host.xfer(1, {8'h0C, 24'h000004, 16'h0}, 12, 10, rx);
    `CHK("wrap_rd", 40'hA1A0A3A2A5, rx)
    `CHK("rd_addr", 24'h000002, rd_addr)
    i_host.xfer(1, {8'h0B, 24'h000004, 16'h0}, 12, 10, rx);
    `CHK("fast_rd", 40'hA1A0A3A2AD, rx)
    i_host.xfer(1, {8'h0E, 24'h000004, 32'h0}, 16, 4, rx);
    `CHK("dtr_rd", 16'hAAAA, rx[15:0])
    `CHK("rd_addr", 24'h000001, rd_addr)
    cmd(1, 8'h98, 2);
    prot(24'h012000, 1'b1);
    write_enable_latch = 1'b1;
    cmd(1, 8'h98, 2);
    prot(24'h012000, 1'b0);
    per_region_protect_select = 1'b0;
    range_protect = 1'b1;
    prot(24'h012000, 1'b1);
    per_region_protect_select = 1'b1;
    cmd(1, {8'h36, 24'h012000}, 8);
    prot(24'h012000, 1'b1);
    prot(24'h022000, 1'b0);
    i_host.xfer(1, {8'h3D, 24'h012000}, 8, 2, rx);
    `CHK("lock_rd", 8'h01, rx[7:0])
    cmd(1, {8'h39, 24'h012000}, 8);
    prot(24'h012000, 1'b0);
    cmd(1, 8'hFF, 2);
    `CHK("mode", 1'b0, four_line_command_mode)
    i_host.xfer(0, {8'h3D, 24'h012000}, 32, 8, rx);
    `CHK("lock_rd", 8'h00, rx[7:0])
    cmd(0, 8'h66, 8);
    cmd(0, 8'h7E, 8);
    cmd(0, 8'h99, 8);
    `CHK("busy", 1'b0, busy)
    prot(24'h012000, 1'b1);
    cmd(0, 8'h98, 8);
    cmd(0, 8'h38, 8);
    cmd(1, 8'h66, 2);
    cmd(1, 8'h99, 2);
    `CHK("busy", 1'b1, busy)
    `CHK("rd_param", 4'h0, rd_param)
    `CHK("mode", 1'b0, four_line_command_mode)
    cmd(0, 8'h98, 8);
    prot(24'h012000, 1'b1);
    for (k = 0; k < 1000 && busy !== 1'b0; k++)
      @(negedge clock);
    `CHK("busy_end", 1'b0, busy)
    // Mid-run reset from four-line mode with altered state
    cmd(0, 8'h98, 8);
    cmd(0, 8'h38, 8);
    cmd(1, {8'hC0, 8'h33}, 4);
    `CHK("rd_param", 4'hF, rd_param)
    rst = 1'b1;
    repeat (4) @(negedge clock);
    rst = 1'b0;
    repeat (8) @(negedge clock);
    `CHK("rd_param", 4'h0, rd_param)
    `CHK("mode", 1'b0, four_line_command_mode)
    prot(24'h012000, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire

// ===== tb/fqlr_host.sv
// Host controller model: chip select, serial clock and data pins
`timescale 1ns/10ps
`default_nettype none
module fqlr_host (
  input wire logic clock, // Pacing clock
  input wire logic [3:0] io_out, // Device data pins
  input wire logic [3:0] io_oe_n, // Device pin enables, low drives
  output logic cs_n, // Chip select, active low
  output logic sck, // Serial clock, idle low
  output logic [3:0] io_in // Host data pins
);
  // Idle pins at time zero
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    io_in = 4'h0;
  end
  // Half of the 80 ns link period
  task automatic half();
    repeat (10) @(negedge clock);
  endtask
  // One frame: nu units out MSB first, nr units back
  task automatic xfer(input bit q, input logic [63:0] tx, input int nu, input int nr, output logic [39:0] rx);
    rx = '0;
    cs_n = 1'b0;
    for (int i = nu - 1; i >= 0; i--)
    begin
      io_in = q ? tx[i*4 +: 4] : {io_in[3:1], tx[i]};
      half();
      sck = 1'b1;
      half();
      sck = 1'b0;
    end
    for (int i = 0; i < nr; i++)
    begin
      // Released lines toggle
      io_in = ~io_in;
      half();
      // A line the device leaves released reads inverted
      rx = q ? {rx[35:0], io_out ^ io_oe_n} : {rx[38:0], io_out[1] ^ io_oe_n[1]};
      sck = 1'b1;
      half();
      sck = 1'b0;
    end
    half();
    cs_n = 1'b1;
    io_in = ~io_in;
    half();
  endtask
endmodule
`default_nettype wire
